// [hw/spt_defs.svh]
`ifndef SPT_DEFS_SVH
`define SPT_DEFS_SVH

// Register offsets on the serial control port (15-bit address space).
`define SPT_OFS_PLL_ENABLE 15'h0280
`define SPT_OFS_PLL_STATUS 15'h0281
`define SPT_OFS_REF_DIV 15'h0289
`define SPT_OFS_OSC_REG 15'h028A
`define SPT_OFS_PD_A 15'h028B
`define SPT_OFS_VAR_A 15'h0290
`define SPT_OFS_PUMP_B 15'h0294
`define SPT_OFS_OSC_A 15'h0296
`define SPT_OFS_OSC_B 15'h0297
`define SPT_OFS_PD_B 15'h0299
`define SPT_OFS_VAR_B 15'h029A
`define SPT_OFS_PUMP_C 15'h029C
`define SPT_OFS_VAR_C 15'h029F
`define SPT_OFS_VAR_D 15'h02A0
`define SPT_OFS_CLK_SETUP 15'h02A4
`define SPT_OFS_SWING 15'h02A5
`define SPT_OFS_TERM_TRIG 15'h02A7
`define SPT_OFS_TERM_A 15'h02AA
`define SPT_OFS_TERM_B 15'h02AB

// Storage slots of the bank; slot count is one above the last index.
`define SPT_REG_COUNT 18
`define SPT_IDX_NONE 5'h1F

// Reset values.
`define SPT_RST_REF_DIV 8'h00
`define SPT_RST_OSC_REG 8'h2B
`define SPT_RST_PD_A 8'h7F
`define SPT_RST_VAR_A 8'h83
`define SPT_RST_PUMP_B 8'hB0
`define SPT_RST_OSC_A 8'h0C
`define SPT_RST_OSC_B 8'h00
`define SPT_RST_PD_B 8'h00
`define SPT_RST_VAR_B 8'hFE
`define SPT_RST_PUMP_C 8'h17
`define SPT_RST_VAR_C 8'h33
`define SPT_RST_VAR_D 8'h08
`define SPT_RST_CLK_SETUP 8'h4B
`define SPT_RST_SWING 8'h00
`define SPT_RST_TERM_TRIG 8'h00
`define SPT_RST_TERM_A 8'hC3
`define SPT_RST_TERM_B 8'h93
`define SPT_RST_PLL_ENABLE 8'h00

// Writable-bit masks; clear bits are reserved, read zero and ignore writes.
`define SPT_WMASK_FULL 8'hFF
`define SPT_WMASK_REF_DIV 8'h07
`define SPT_WMASK_ONE 8'h01
`define SPT_WMASK_PLL_ENABLE 8'h05

// Field positions.
`define SPT_BIT_REF_CFG 2
`define SPT_BIT_PLL_EN 0
`define SPT_BIT_PLL_RECAL 2
`define SPT_BIT_TRIG 0
`define SPT_BIT_LOCK 0

// Divider codes and factors.
`define SPT_DIV_CODE_4 2'b00
`define SPT_DIV_CODE_2 2'b01
`define SPT_DIV_CODE_1 2'b10
`define SPT_DIV_FACTOR_4 3'h4
`define SPT_DIV_FACTOR_2 3'h2
`define SPT_DIV_FACTOR_1 3'h1
`define SPT_DIV_FACTOR_BAD 3'h0

// Serial frame: one direction bit, 15 address bits, 8 data bits.
`define SPT_CMD_LAST 5'h0F
`define SPT_FRAME_LAST 5'h17
`define SPT_FRAME_BITS 5'h18
`define SPT_DATA_FIRST 5'h10

`endif

// [hw/spt_pkg.sv]
`include "spt_defs.svh"

package spt_pkg;

	typedef logic [`SPT_REG_COUNT-1:0][7:0] spt_bank_t;

	typedef struct packed {
		logic [1:0] sclk_sync;
		logic [1:0] csb_sync;
		logic [1:0] sdi_sync;
		logic [1:0] lock_sync;
		logic sclk_prev;
		logic [4:0] bit_cnt;
		logic [15:0] cmd;
		logic [7:0] shift;
		logic [7:0] rd_byte;
		logic sdo;
		logic sdo_oe;
		spt_bank_t regs;
		logic [2:0] div_factor;
		logic term_cal_start;
		logic pll_cal_start;
	} spt_state_t;

endpackage

// [hw/spt_config_regs.sv]
`timescale 1ns/1ps
`include "spt_defs.svh"

module spt_config_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial control port pins
	input wire logic spi_sclk,
	input wire logic spi_csb,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// Analog PLL status
	input wire logic link_pll_locked_in,
	// Link PLL controls
	output logic [1:0] pll_ref_divide_select,
	output logic [2:0] pll_ref_divide_factor,
	output logic pll_ref_config_bit,
	output logic [7:0] pll_osc_regulator_value,
	output logic [7:0] pll_powerdown_value_a,
	output logic [7:0] pll_powerdown_value_b,
	output logic [7:0] pll_varactor_value_a,
	output logic [7:0] pll_varactor_value_b,
	output logic [7:0] pll_varactor_value_c,
	output logic [7:0] pll_varactor_value_d,
	output logic [7:0] pll_pump_value_b,
	output logic [7:0] pll_pump_value_c,
	output logic [7:0] pll_osc_value_a,
	output logic [7:0] pll_osc_value_b,
	output logic [7:0] clock_setup_value,
	output logic link_pll_enable,
	output logic link_pll_cal_start,
	// Sync outputs and lane terminations
	output logic sync_output_swing_select,
	output logic lane_term_cal_start,
	output logic [7:0] lane_term_setup_value_a,
	output logic [7:0] lane_term_setup_value_b
);

	localparam logic [4:0] IDX_REF_DIV = 5'h00;
	localparam logic [4:0] IDX_OSC_REG = 5'h01;
	localparam logic [4:0] IDX_PD_A = 5'h02;
	localparam logic [4:0] IDX_VAR_A = 5'h03;
	localparam logic [4:0] IDX_PUMP_B = 5'h04;
	localparam logic [4:0] IDX_OSC_A = 5'h05;
	localparam logic [4:0] IDX_OSC_B = 5'h06;
	localparam logic [4:0] IDX_PD_B = 5'h07;
	localparam logic [4:0] IDX_VAR_B = 5'h08;
	localparam logic [4:0] IDX_PUMP_C = 5'h09;
	localparam logic [4:0] IDX_VAR_C = 5'h0A;
	localparam logic [4:0] IDX_VAR_D = 5'h0B;
	localparam logic [4:0] IDX_CLK_SETUP = 5'h0C;
	localparam logic [4:0] IDX_SWING = 5'h0D;
	localparam logic [4:0] IDX_TERM_TRIG = 5'h0E;
	localparam logic [4:0] IDX_TERM_A = 5'h0F;
	localparam logic [4:0] IDX_TERM_B = 5'h10;
	localparam logic [4:0] IDX_PLL_ENABLE = 5'h11;

	// Slot 0 sits in the lowest byte, so the lists run from the last slot down.
	localparam spt_pkg::spt_bank_t RESET_BANK = {
		`SPT_RST_PLL_ENABLE, `SPT_RST_TERM_B, `SPT_RST_TERM_A, `SPT_RST_TERM_TRIG,
		`SPT_RST_SWING, `SPT_RST_CLK_SETUP, `SPT_RST_VAR_D, `SPT_RST_VAR_C,
		`SPT_RST_PUMP_C, `SPT_RST_VAR_B, `SPT_RST_PD_B, `SPT_RST_OSC_B,
		`SPT_RST_OSC_A, `SPT_RST_PUMP_B, `SPT_RST_VAR_A, `SPT_RST_PD_A,
		`SPT_RST_OSC_REG, `SPT_RST_REF_DIV};
	localparam spt_pkg::spt_bank_t WMASK_BANK = {
		`SPT_WMASK_PLL_ENABLE, `SPT_WMASK_FULL, `SPT_WMASK_FULL, `SPT_WMASK_ONE,
		`SPT_WMASK_ONE, `SPT_WMASK_FULL, `SPT_WMASK_FULL, `SPT_WMASK_FULL,
		`SPT_WMASK_FULL, `SPT_WMASK_FULL, `SPT_WMASK_FULL, `SPT_WMASK_FULL,
		`SPT_WMASK_FULL, `SPT_WMASK_FULL, `SPT_WMASK_FULL, `SPT_WMASK_FULL,
		`SPT_WMASK_FULL, `SPT_WMASK_REF_DIV};

	spt_pkg::spt_state_t s_r;
	spt_pkg::spt_state_t s_nxt;

	// Maps a control-port address to a storage slot, or to no slot.
	function automatic logic [4:0] reg_index(input logic [14:0] addr);
		logic [4:0] idx;
		idx = `SPT_IDX_NONE;
		unique case (addr)
			`SPT_OFS_REF_DIV: idx = IDX_REF_DIV;
			`SPT_OFS_OSC_REG: idx = IDX_OSC_REG;
			`SPT_OFS_PD_A: idx = IDX_PD_A;
			`SPT_OFS_VAR_A: idx = IDX_VAR_A;
			`SPT_OFS_PUMP_B: idx = IDX_PUMP_B;
			`SPT_OFS_OSC_A: idx = IDX_OSC_A;
			`SPT_OFS_OSC_B: idx = IDX_OSC_B;
			`SPT_OFS_PD_B: idx = IDX_PD_B;
			`SPT_OFS_VAR_B: idx = IDX_VAR_B;
			`SPT_OFS_PUMP_C: idx = IDX_PUMP_C;
			`SPT_OFS_VAR_C: idx = IDX_VAR_C;
			`SPT_OFS_VAR_D: idx = IDX_VAR_D;
			`SPT_OFS_CLK_SETUP: idx = IDX_CLK_SETUP;
			`SPT_OFS_SWING: idx = IDX_SWING;
			`SPT_OFS_TERM_TRIG: idx = IDX_TERM_TRIG;
			`SPT_OFS_TERM_A: idx = IDX_TERM_A;
			`SPT_OFS_TERM_B: idx = IDX_TERM_B;
			`SPT_OFS_PLL_ENABLE: idx = IDX_PLL_ENABLE;
			default: idx = `SPT_IDX_NONE;
		endcase
		return idx;
	endfunction

	logic sclk_rise;
	logic sclk_fall;
	logic frame_active;
	logic [14:0] rd_addr;
	logic [4:0] rd_idx;
	logic [4:0] wr_idx;
	logic [7:0] wr_data;
	logic [7:0] wr_old;
	logic [7:0] wr_new;
	logic [4:0] out_pos;

	assign sclk_rise = s_r.sclk_sync[1] & ~s_r.sclk_prev;
	assign sclk_fall = ~s_r.sclk_sync[1] & s_r.sclk_prev;
	assign frame_active = ~s_r.csb_sync[1];
	assign rd_addr = {s_r.cmd[13:0], s_r.sdi_sync[1]};
	assign rd_idx = reg_index(rd_addr);
	assign wr_idx = reg_index(s_r.cmd[14:0]);
	assign wr_data = {s_r.shift[6:0], s_r.sdi_sync[1]};
	assign wr_old = (wr_idx == `SPT_IDX_NONE) ? 8'h00 : s_r.regs[wr_idx];
	assign wr_new = (wr_idx == `SPT_IDX_NONE) ? 8'h00 :
		((wr_old & ~WMASK_BANK[wr_idx]) | (wr_data & WMASK_BANK[wr_idx]));
	assign out_pos = `SPT_FRAME_LAST - s_r.bit_cnt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.sclk_sync = {s_r.sclk_sync[0], spi_sclk};
		s_nxt.csb_sync = {s_r.csb_sync[0], spi_csb};
		s_nxt.sdi_sync = {s_r.sdi_sync[0], spi_sdi};
		s_nxt.lock_sync = {s_r.lock_sync[0], link_pll_locked_in};
		s_nxt.sclk_prev = s_r.sclk_sync[1];
		s_nxt.term_cal_start = 1'b0;
		s_nxt.pll_cal_start = 1'b0;
		if (!frame_active) begin
			s_nxt.bit_cnt = 5'h00;
			s_nxt.sdo_oe = 1'b0;
		end else if (sclk_rise && s_r.bit_cnt != `SPT_FRAME_BITS) begin
			s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
			if (s_r.bit_cnt <= `SPT_CMD_LAST) begin
				s_nxt.cmd = {s_r.cmd[14:0], s_r.sdi_sync[1]};
			end else begin
				s_nxt.shift = wr_data;
			end
			// The read value is taken once the address is whole, so a register that
			// changes while it is shifted out still reads back consistently.
			if (s_r.bit_cnt == `SPT_CMD_LAST) begin
				if (rd_idx != `SPT_IDX_NONE) begin
					s_nxt.rd_byte = s_r.regs[rd_idx];
				end else if (rd_addr == `SPT_OFS_PLL_STATUS) begin
					s_nxt.rd_byte = {7'h00, s_r.lock_sync[1]};
				end else begin
					s_nxt.rd_byte = 8'h00;
				end
			end
			if (s_r.bit_cnt == `SPT_FRAME_LAST && !s_r.cmd[15] && wr_idx != `SPT_IDX_NONE) begin
				s_nxt.regs[wr_idx] = wr_new;
				if (wr_idx == IDX_TERM_TRIG) begin
					s_nxt.term_cal_start = ~wr_old[`SPT_BIT_TRIG] & wr_new[`SPT_BIT_TRIG];
				end
				if (wr_idx == IDX_PLL_ENABLE) begin
					s_nxt.pll_cal_start = wr_new[`SPT_BIT_PLL_EN] & (~wr_old[`SPT_BIT_PLL_EN] |
						(~wr_old[`SPT_BIT_PLL_RECAL] & wr_new[`SPT_BIT_PLL_RECAL]));
				end
			end
		end else if (sclk_fall && s_r.cmd[15] && s_r.bit_cnt >= `SPT_DATA_FIRST &&
			s_r.bit_cnt <= `SPT_FRAME_LAST) begin
			s_nxt.sdo = s_r.rd_byte[out_pos[2:0]];
			s_nxt.sdo_oe = 1'b1;
		end
		unique case (s_nxt.regs[IDX_REF_DIV][1:0])
			`SPT_DIV_CODE_4: s_nxt.div_factor = `SPT_DIV_FACTOR_4;
			`SPT_DIV_CODE_2: s_nxt.div_factor = `SPT_DIV_FACTOR_2;
			`SPT_DIV_CODE_1: s_nxt.div_factor = `SPT_DIV_FACTOR_1;
			default: s_nxt.div_factor = `SPT_DIV_FACTOR_BAD;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.regs <= RESET_BANK;
			s_r.div_factor <= `SPT_DIV_FACTOR_4;
			s_r.sclk_sync <= 2'h0;
			s_r.csb_sync <= 2'h3;
			s_r.sclk_prev <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign spi_sdo = s_r.sdo;
	assign spi_sdo_oe = s_r.sdo_oe;
	assign pll_ref_divide_select = s_r.regs[IDX_REF_DIV][1:0];
	assign pll_ref_divide_factor = s_r.div_factor;
	assign pll_ref_config_bit = s_r.regs[IDX_REF_DIV][`SPT_BIT_REF_CFG];
	assign pll_osc_regulator_value = s_r.regs[IDX_OSC_REG];
	assign pll_powerdown_value_a = s_r.regs[IDX_PD_A];
	assign pll_powerdown_value_b = s_r.regs[IDX_PD_B];
	assign pll_varactor_value_a = s_r.regs[IDX_VAR_A];
	assign pll_varactor_value_b = s_r.regs[IDX_VAR_B];
	assign pll_varactor_value_c = s_r.regs[IDX_VAR_C];
	assign pll_varactor_value_d = s_r.regs[IDX_VAR_D];
	assign pll_pump_value_b = s_r.regs[IDX_PUMP_B];
	assign pll_pump_value_c = s_r.regs[IDX_PUMP_C];
	assign pll_osc_value_a = s_r.regs[IDX_OSC_A];
	assign pll_osc_value_b = s_r.regs[IDX_OSC_B];
	assign clock_setup_value = s_r.regs[IDX_CLK_SETUP];
	assign link_pll_enable = s_r.regs[IDX_PLL_ENABLE][`SPT_BIT_PLL_EN];
	assign link_pll_cal_start = s_r.pll_cal_start;
	assign sync_output_swing_select = s_r.regs[IDX_SWING][0];
	assign lane_term_cal_start = s_r.term_cal_start;
	assign lane_term_setup_value_a = s_r.regs[IDX_TERM_A];
	assign lane_term_setup_value_b = s_r.regs[IDX_TERM_B];

	logic write_commit;
	assign write_commit = frame_active && sclk_rise && s_r.bit_cnt == `SPT_FRAME_LAST && !s_r.cmd[15];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	reset_values_a: assert property ($fell(rst) |-> pll_osc_regulator_value == 8'h2B &&
		pll_powerdown_value_a == 8'h7F && pll_varactor_value_a == 8'h83 && pll_pump_value_b == 8'hB0 &&
		pll_osc_value_a == 8'h0C && pll_osc_value_b == 8'h00 && pll_powerdown_value_b == 8'h00 &&
		pll_varactor_value_b == 8'hFE && pll_pump_value_c == 8'h17 && pll_varactor_value_c == 8'h33 &&
		pll_varactor_value_d == 8'h08 && clock_setup_value == 8'h4B && lane_term_setup_value_a == 8'hC3 &&
		lane_term_setup_value_b == 8'h93 && !pll_ref_config_bit)
		else $error("Bank does not hold its reset values.");
	div_factor_map_a: assert property (pll_ref_divide_factor == (pll_ref_divide_select == 2'b00 ? 3'h4 :
		pll_ref_divide_select == 2'b01 ? 3'h2 : pll_ref_divide_select == 2'b10 ? 3'h1 : 3'h0))
		else $error("Divider factor does not match the code.");
	reserved_zero_a: assert property (s_r.regs[IDX_REF_DIV][7:3] == 5'h00 &&
		s_r.regs[IDX_SWING][7:1] == 7'h00 && s_r.regs[IDX_TERM_TRIG][7:1] == 7'h00 &&
		s_r.regs[IDX_PLL_ENABLE][7:3] == 5'h00 && !s_r.regs[IDX_PLL_ENABLE][1])
		else $error("A reserved bit holds a one.");
	swing_by_write_a: assert property ($changed(sync_output_swing_select) |-> $past(write_commit))
		else $error("Swing select changed without a write.");
	term_pulse_cause_a: assert property (lane_term_cal_start |->
		$past(write_commit && wr_idx == IDX_TERM_TRIG && !s_r.regs[IDX_TERM_TRIG][0] && wr_data[0]))
		else $error("Termination calibration without a rising write.");
	term_pulse_fire_a: assert property (write_commit && wr_idx == IDX_TERM_TRIG &&
		!s_r.regs[IDX_TERM_TRIG][0] && wr_data[0] |=> lane_term_cal_start ##1 !lane_term_cal_start)
		else $error("Termination calibration pulse missing or too long.");
	pll_cal_start_a: assert property (write_commit && wr_idx == IDX_PLL_ENABLE &&
		!link_pll_enable && wr_data[0] |=> link_pll_cal_start && link_pll_enable)
		else $error("PLL enable did not start calibration.");
	lock_readback_a: assert property (s_r.lock_sync[1] == $past(link_pll_locked_in, 2))
		else $error("Lock status lags by the wrong amount.");
	sdo_frame_a: assert property (spi_sdo_oe |-> s_r.cmd[15] && s_r.bit_cnt >= 5'h10)
		else $error("Data out driven outside a read data phase.");

	term_cal_c: cover property (lane_term_cal_start);
	pll_cal_c: cover property (link_pll_cal_start);
	read_frame_c: cover property ($rose(spi_sdo_oe));
	write_frame_c: cover property (write_commit && wr_idx != `SPT_IDX_NONE);

endmodule // spt_config_regs

// [bench/testbench.sv]
`timescale 1ns/1ps
`include "spt_defs.svh"

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end

module testbench;
	typedef struct {logic [14:0] a; logic [7:0] rv; logic [7:0] wv; logic [7:0] ev;} tb_row_t;
	logic clk = 0, rst = 1, spi_sclk = 0, spi_csb = 1, spi_sdi = 0, lock_in = 0;
	logic spi_sdo, spi_sdo_oe, pll_ref_config_bit, link_pll_enable, link_pll_cal_start, swing, term_cal;
	logic [1:0] div_sel;
	logic [2:0] div_fac;
	logic [7:0] osc_reg, pd_a, pd_b, var_a, var_b, var_c, var_d, pump_b, pump_c, osc_a, osc_b, clk_setup;
	logic [7:0] term_a, term_b, rdv;
	int fails = 0, total_checks = 0, cycles = 0, term_pulses = 0, pll_pulses = 0;
	logic [2:0] fac[4] = '{`SPT_DIV_FACTOR_4, `SPT_DIV_FACTOR_2, `SPT_DIV_FACTOR_1, `SPT_DIV_FACTOR_BAD};
	tb_row_t rows[19] = '{
		'{`SPT_OFS_REF_DIV, 8'h00, 8'hff, 8'h07},
		'{`SPT_OFS_OSC_REG, 8'h2b, 8'h7b, 8'h7b},
		'{`SPT_OFS_PD_A, 8'h7f, 8'h00, 8'h00},
		'{`SPT_OFS_VAR_A, 8'h83, 8'h89, 8'h89},
		'{`SPT_OFS_PUMP_B, 8'hb0, 8'h24, 8'h24},
		'{`SPT_OFS_OSC_A, 8'h0c, 8'h03, 8'h03},
		'{`SPT_OFS_OSC_B, 8'h00, 8'h0d, 8'h0d},
		'{`SPT_OFS_PD_B, 8'h00, 8'h02, 8'h02},
		'{`SPT_OFS_VAR_B, 8'hfe, 8'h8e, 8'h8e},
		'{`SPT_OFS_PUMP_C, 8'h17, 8'h2a, 8'h2a},
		'{`SPT_OFS_VAR_C, 8'h33, 8'h78, 8'h78},
		'{`SPT_OFS_VAR_D, 8'h08, 8'h06, 8'h06},
		'{`SPT_OFS_CLK_SETUP, 8'h4b, 8'hff, 8'hff},
		'{`SPT_OFS_SWING, 8'h00, 8'hff, 8'h01},
		'{`SPT_OFS_TERM_A, 8'hc3, 8'hb7, 8'hb7},
		'{`SPT_OFS_TERM_B, 8'h93, 8'h87, 8'h87},
		'{`SPT_OFS_TERM_TRIG, 8'h00, 8'hfe, 8'h00},
		'{`SPT_OFS_PLL_ENABLE, 8'h00, 8'hfa, 8'h00},
		'{15'h02a6, 8'h00, 8'hff, 8'h00}
	};

	spt_config_regs uut (.clk(clk), .rst(rst), .spi_sclk(spi_sclk), .spi_csb(spi_csb), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .link_pll_locked_in(lock_in),
		.pll_ref_divide_select(div_sel), .pll_ref_divide_factor(div_fac), .pll_ref_config_bit(pll_ref_config_bit),
		.pll_osc_regulator_value(osc_reg), .pll_powerdown_value_a(pd_a), .pll_powerdown_value_b(pd_b),
		.pll_varactor_value_a(var_a), .pll_varactor_value_b(var_b), .pll_varactor_value_c(var_c),
		.pll_varactor_value_d(var_d), .pll_pump_value_b(pump_b), .pll_pump_value_c(pump_c),
		.pll_osc_value_a(osc_a), .pll_osc_value_b(osc_b), .clock_setup_value(clk_setup),
		.link_pll_enable(link_pll_enable), .link_pll_cal_start(link_pll_cal_start),
		.sync_output_swing_select(swing), .lane_term_cal_start(term_cal),
		.lane_term_setup_value_a(term_a), .lane_term_setup_value_b(term_b));

	always #25 clk = ~clk;

	// Pulses are counted per cycle, so a pulse that stands two cycles shows up as two.
	// Counting on the falling edge keeps clear of the edge that launches the pulse.
	always @(negedge clk) begin
		cycles++;
		if (term_cal === 1'b1) term_pulses++;
		if (link_pll_cal_start === 1'b1) pll_pulses++;
		if (cycles == 60000) begin
			fails++;
			end_of_test();
		end
	end

	function automatic logic [7:0] port_of(input logic [14:0] a, input logic [7:0] fb);
		case (a)
			`SPT_OFS_REF_DIV: return {5'h00, pll_ref_config_bit, div_sel};
			`SPT_OFS_OSC_REG: return osc_reg;
			`SPT_OFS_PD_A: return pd_a;
			`SPT_OFS_VAR_A: return var_a;
			`SPT_OFS_PUMP_B: return pump_b;
			`SPT_OFS_OSC_A: return osc_a;
			`SPT_OFS_OSC_B: return osc_b;
			`SPT_OFS_PD_B: return pd_b;
			`SPT_OFS_VAR_B: return var_b;
			`SPT_OFS_PUMP_C: return pump_c;
			`SPT_OFS_VAR_C: return var_c;
			`SPT_OFS_VAR_D: return var_d;
			`SPT_OFS_CLK_SETUP: return clk_setup;
			`SPT_OFS_SWING: return {7'h00, swing};
			`SPT_OFS_TERM_A: return term_a;
			`SPT_OFS_TERM_B: return term_b;
			`SPT_OFS_PLL_ENABLE: return {7'h00, link_pll_enable};
			default: return fb;
		endcase
	endfunction

	// Six clocks per serial phase leave room for the pin synchronisers; nbits below 24 cuts a frame short.
	task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, input int nbits,
		output logic [7:0] rv);
		logic [23:0] fr;
		fr = {rd, a, wd};
		rv = 8'h00;
		@(negedge clk);
		spi_csb = 0;
		for (int i = 0; i < nbits; i++) begin
			spi_sdi = fr[23-i];
			repeat (6) @(negedge clk);
			if (i >= 16) rv[23-i] = spi_sdo;
			if (i >= 16 && rd) `CHK("data enable", 1'b1, spi_sdo_oe)
			spi_sclk = 1;
			repeat (6) @(negedge clk);
			spi_sclk = 0;
		end
		repeat (6) @(negedge clk);
		spi_csb = 1;
		repeat (6) @(negedge clk);
		`CHK("data released", 1'b0, spi_sdo_oe)
	endtask

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] dummy;
		xfer(1'b0, a, d, 24, dummy);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		repeat (4) @(negedge clk);
		foreach (rows[k]) begin
			xfer(1'b1, rows[k].a, 8'h00, 24, rdv);
			`CHK("reset readback", rows[k].rv, rdv)
			wr(rows[k].a, rows[k].wv);
			xfer(1'b1, rows[k].a, 8'h00, 24, rdv);
			`CHK("readback", rows[k].ev, rdv)
			`CHK("port level", rows[k].ev, port_of(rows[k].a, rows[k].ev))
		end
		`CHK("no stray pulse", 0, term_pulses + pll_pulses)
		$display("test table done");
		for (int c = 0; c < 4; c++) begin
			wr(`SPT_OFS_REF_DIV, {5'h1f, 1'b1, c[1:0]});
			`CHK("divider code", c[1:0], div_sel)
			`CHK("divider factor", fac[c], div_fac)
			`CHK("config bit", 1'b1, pll_ref_config_bit)
		end
		$display("test divider done");
		wr(`SPT_OFS_TERM_TRIG, 8'h01);
		`CHK("cal pulses", 1, term_pulses)
		wr(`SPT_OFS_TERM_TRIG, 8'hff);
		`CHK("cal pulses held", 1, term_pulses)
		xfer(1'b1, `SPT_OFS_TERM_TRIG, 8'h00, 24, rdv);
		`CHK("trigger readback", 8'h01, rdv)
		wr(`SPT_OFS_TERM_TRIG, 8'h00);
		wr(`SPT_OFS_TERM_TRIG, 8'h01);
		`CHK("cal pulses again", 2, term_pulses)
		$display("test termination done");
		wr(`SPT_OFS_PLL_ENABLE, 8'h01);
		`CHK("pll enable", 1'b1, link_pll_enable)
		`CHK("pll cal pulses", 1, pll_pulses)
		wr(`SPT_OFS_PLL_ENABLE, 8'h05);
		`CHK("pll recal pulses", 2, pll_pulses)
		xfer(1'b1, `SPT_OFS_PLL_ENABLE, 8'h00, 24, rdv);
		`CHK("pll enable readback", 8'h05, rdv)
		lock_in = 1;
		xfer(1'b1, `SPT_OFS_PLL_STATUS, 8'h00, 24, rdv);
		`CHK("lock high", 8'h01, rdv)
		lock_in = 0;
		xfer(1'b1, `SPT_OFS_PLL_STATUS, 8'h00, 24, rdv);
		`CHK("lock low", 8'h00, rdv)
		$display("test pll done");
		xfer(1'b0, `SPT_OFS_OSC_REG, 8'h11, 20, rdv);
		`CHK("short frame", 8'h7b, osc_reg)
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		repeat (4) @(negedge clk);
		`CHK("reset varactor", 8'h83, var_a)
		`CHK("reset term b", 8'h93, term_b)
		`CHK("reset swing", 1'b0, swing)
		`CHK("reset factor", 3'h4, div_fac)
		$display("test reset done");
		end_of_test();
	end
endmodule // testbench
